// ### hw/lmfbw_pkg.sv
// Shared constants and types for the local-master fast back-to-back write bridge
package lmfbw_pkg;
    // ****************************************
    // Progress state codes
    // ****************************************
    localparam logic [3:0] PROG_IDLE = 4'h0;
    localparam logic [3:0] PROG_ADDR_LOAD = 4'h1;
    localparam logic [3:0] PROG_BUS_TRANS = 4'h2;
    localparam logic [3:0] PROG_CHAINED = 4'h3;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PHASES = 8'h08;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int BEAT_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 72;
    localparam logic [11:0] BEATS_ZERO = 12'h000;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] be;
    } lmfbw_word_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [11:0] beats;
    } lmfbw_request_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_ADDR, ST_DECODE, ST_SETTLE, ST_DATA, ST_TURN, ST_LAST
    } lmfbw_state_t;
endpackage

// ### hw/lmfbw_fifo.sv
// Parameterised FIFO holding quadwords taken from the local master
`timescale 1ns/1ns
module lmfbw_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // space available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // data available
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data, // head word
    output logic [$clog2(DEPTH):0] level // words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = count != DEPTH[AW:0];
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign level = count;

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // lmfbw_fifo

// ### hw/lmfbw_beat_counter.sv
// Loadable down counter for the remaining data phases of a burst
`timescale 1ns/1ns
module lmfbw_beat_counter #(
    parameter int WIDTH = 12
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic load, // load start value
    input wire logic [WIDTH-1:0] start, // start value
    input wire logic dec, // count one down
    output logic [WIDTH-1:0] value // current count
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= '0;
        end else if (load) begin
            value <= start;
        end else if (dec && value != '0) begin
            value <= value - 1'b1;
        end
    end
endmodule // lmfbw_beat_counter

// ### hw/lmfbw_top.sv
// Local-master side of a PCI master doing 64-bit fast back-to-back write bursts
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module lmfbw_top (
    input wire logic MCLK, // clock, 10 MHz
    input wire logic RESETN, // async reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic GNT_N, // bus grant
    output logic REQ_N, // bus request
    output logic FRAME_N, // frame level driven
    output logic FRAME_OE, // frame drive enable
    output logic IRDY_N, // initiator ready level driven
    output logic IRDY_OE, // initiator ready drive enable
    output logic REQ64_N, // 64-bit request level driven
    output logic REQ64_OE, // 64-bit request drive enable
    input wire logic DEVSEL_N, // target selected
    input wire logic TRDY_N, // target ready
    input wire logic ACK64_N, // target accepts 64-bit
    output logic [63:0] AD_OUT, // address/data driven
    output logic AD_OE, // address/data drive enable
    output logic [7:0] CBE_OUT, // command/byte enables driven
    output logic CBE_OE, // command/byte enables drive enable
    input wire logic [63:0] LOCAL_DATA_IN, // local write data or address
    input wire logic [7:0] LOCAL_BYTE_ENABLES_IN, // local byte enables, active low
    input wire logic [3:0] LOCAL_COMMAND_IN, // local bus command
    input wire logic [11:0] REQUESTED_BEAT_COUNT, // local burst length
    input wire logic LOCAL_READY_N, // local data ready
    input wire logic LOCAL_WIDE_REQUEST_N, // local 64-bit request
    output logic LOCAL_GRANT_N, // local grant
    output logic LOW_WORD_TAKEN_N, // low word taken strobe
    output logic HIGH_WORD_TAKEN_N, // high word taken strobe
    output logic [3:0] MASTER_PROGRESS_STATE, // progress code
    output logic WIDE_TRANSFER_FLAG_N // 64-bit transfer indicator
);
    lmfbw_pkg::lmfbw_state_t state;
    lmfbw_pkg::lmfbw_state_t next_state;
    lmfbw_pkg::lmfbw_request_t req_latch;
    lmfbw_pkg::lmfbw_word_t push_word;
    lmfbw_pkg::lmfbw_word_t head_word;
    logic [lmfbw_pkg::FIFO_W-1:0] head_bits;
    logic [3:0] progress;
    logic [3:0] next_progress;
    logic frame_n;
    logic next_frame_n;
    logic irdy_n;
    logic next_irdy_n;
    logic req64_n;
    logic next_req64_n;
    logic drive_on;
    logic next_drive_on;
    logic [63:0] ad;
    logic [63:0] next_ad;
    logic [7:0] cbe;
    logic [7:0] next_cbe;
    logic pop;
    logic taken_n;
    logic next_taken_n;
    logic req_n;
    logic grant_n;
    logic wide_n;
    logic done_q;
    logic phase_done;
    logic latch_req;
    logic start_ok;
    logic [11:0] remaining;
    logic [11:0] eff_left;
    logic [11:0] fetch_left;
    logic [11:0] fetch_need;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [3:0] fifo_level;
    logic fifo_room;
    logic [31:0] control;
    logic [31:0] phases;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;

    // ****************************************
    // Output ports straight from flip-flops
    // ****************************************
    assign FRAME_N = frame_n;
    assign FRAME_OE = drive_on;
    assign IRDY_N = irdy_n;
    assign IRDY_OE = drive_on;
    assign REQ64_N = req64_n;
    assign REQ64_OE = drive_on;
    assign AD_OUT = ad;
    assign AD_OE = drive_on;
    assign CBE_OUT = cbe;
    assign CBE_OE = drive_on;
    assign REQ_N = req_n;
    assign LOCAL_GRANT_N = grant_n;
    assign LOW_WORD_TAKEN_N = taken_n;
    assign HIGH_WORD_TAKEN_N = taken_n;
    assign MASTER_PROGRESS_STATE = progress;
    assign WIDE_TRANSFER_FLAG_N = wide_n;
    assign PRDATA = prdata;
    assign PREADY = pready;
    assign PSLVERR = pslverr;

    // ****************************************
    // Data buffer and beat counter
    // ****************************************
    assign push_word.data = LOCAL_DATA_IN;
    assign push_word.be = LOCAL_BYTE_ENABLES_IN;
    assign head_word = lmfbw_pkg::lmfbw_word_t'(head_bits);

    lmfbw_fifo #(
        .WIDTH(lmfbw_pkg::FIFO_W),
        .DEPTH(lmfbw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RESETN),
        .in_valid(!taken_n),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(head_bits),
        .level(fifo_level)
    );

    lmfbw_beat_counter #(
        .WIDTH(lmfbw_pkg::BEAT_W)
    ) u_beats (
        .clk(MCLK),
        .rst_n(RESETN),
        .load(state == lmfbw_pkg::ST_ADDR),
        .start(req_latch.beats),
        .dec(done_q),
        .value(remaining)
    );

    assign phase_done = !irdy_n && !TRDY_N;
    // Counter lags a completion by one cycle, so fold the pending decrement in
    assign eff_left = remaining - {11'h000, done_q};
    assign start_ok = control[lmfbw_pkg::CTRL_ENABLE_BIT];
    assign latch_req = !LOCAL_WIDE_REQUEST_N && !grant_n && start_ok;

    // A strobe already low will push one more word, so leave room for it
    assign fifo_room = fifo_in_ready && !(!taken_n && fifo_level == 4'h7);
    assign fetch_need = taken_n ? 12'h000 : 12'h001;

    // ****************************************
    // Transaction sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_progress = progress;
        next_frame_n = frame_n;
        next_irdy_n = irdy_n;
        next_req64_n = req64_n;
        next_drive_on = drive_on;
        next_ad = ad;
        next_cbe = cbe;
        pop = 1'b0;
        case (state)
            lmfbw_pkg::ST_IDLE: begin
                if (latch_req) begin
                    next_state = lmfbw_pkg::ST_LOAD;
                    next_progress = lmfbw_pkg::PROG_ADDR_LOAD;
                end else begin
                    next_progress = lmfbw_pkg::PROG_IDLE;
                end
            end
            lmfbw_pkg::ST_LOAD: begin
                if (!GNT_N) begin
                    next_state = lmfbw_pkg::ST_ADDR;
                    next_frame_n = 1'b0;
                    next_req64_n = 1'b0;
                    next_drive_on = 1'b1;
                    next_ad = {32'h0000_0000, req_latch.addr};
                    next_cbe = {4'h0, req_latch.cmd};
                    next_progress = lmfbw_pkg::PROG_BUS_TRANS;
                end
            end
            lmfbw_pkg::ST_ADDR: begin
                next_state = lmfbw_pkg::ST_DECODE;
            end
            lmfbw_pkg::ST_DECODE: begin
                if (!DEVSEL_N) begin
                    next_state = lmfbw_pkg::ST_SETTLE;
                end
            end
            lmfbw_pkg::ST_SETTLE: begin
                // Frame stays asserted; irdy waits for a word in the buffer
                if (fifo_out_valid) begin
                    pop = 1'b1;
                    next_ad = head_word.data;
                    next_cbe = head_word.be;
                    next_irdy_n = 1'b0;
                    if (remaining == 12'h001) begin
                        next_frame_n = 1'b1;
                        next_req64_n = 1'b1;
                        next_state = lmfbw_pkg::ST_LAST;
                    end else begin
                        next_state = lmfbw_pkg::ST_DATA;
                    end
                end
            end
            lmfbw_pkg::ST_DATA: begin
                if (phase_done && eff_left == 12'h002 && !LOCAL_WIDE_REQUEST_N) begin
                    next_irdy_n = 1'b1;
                    next_progress = lmfbw_pkg::PROG_CHAINED;
                    next_state = lmfbw_pkg::ST_TURN;
                end else if (phase_done || irdy_n) begin
                    if (fifo_out_valid) begin
                        pop = 1'b1;
                        next_ad = head_word.data;
                        next_cbe = head_word.be;
                        next_irdy_n = 1'b0;
                        // After a stall with irdy high the count has settled already
                        if (eff_left == (phase_done ? 12'h002 : 12'h001)) begin
                            next_frame_n = 1'b1;
                            next_req64_n = 1'b1;
                            next_state = lmfbw_pkg::ST_LAST;
                        end
                    end else begin
                        next_irdy_n = 1'b1;
                    end
                end
            end
            lmfbw_pkg::ST_TURN: begin
                if (fifo_out_valid) begin
                    pop = 1'b1;
                    next_ad = head_word.data;
                    next_cbe = head_word.be;
                    next_irdy_n = 1'b0;
                    next_frame_n = 1'b1;
                    next_req64_n = 1'b1;
                    next_state = lmfbw_pkg::ST_LAST;
                end
            end
            lmfbw_pkg::ST_LAST: begin
                if (phase_done) begin
                    next_irdy_n = 1'b1;
                    next_drive_on = 1'b0;
                    if (latch_req) begin
                        next_state = lmfbw_pkg::ST_LOAD;
                        next_progress = lmfbw_pkg::PROG_ADDR_LOAD;
                    end else begin
                        next_state = lmfbw_pkg::ST_IDLE;
                        next_progress = lmfbw_pkg::PROG_IDLE;
                    end
                end
            end
            default: begin
                next_state = lmfbw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= lmfbw_pkg::ST_IDLE;
            progress <= lmfbw_pkg::PROG_IDLE;
        end else begin
            state <= next_state;
            progress <= next_progress;
        end
    end

    // PCI drive: frame held low for the whole burst until the last phase
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
            req64_n <= 1'b1;
            drive_on <= 1'b0;
            ad <= 64'h0000_0000_0000_0000;
            cbe <= 8'h00;
        end else begin
            frame_n <= next_frame_n;
            irdy_n <= next_irdy_n;
            req64_n <= next_req64_n;
            drive_on <= next_drive_on;
            ad <= next_ad;
            cbe <= next_cbe;
        end
    end

    // Request latch, taken while the address-loading code is issued
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            req_latch <= '0;
        end else if (next_progress == lmfbw_pkg::PROG_ADDR_LOAD
                && progress != lmfbw_pkg::PROG_ADDR_LOAD) begin
            req_latch.addr <= LOCAL_DATA_IN[31:0];
            req_latch.cmd <= LOCAL_COMMAND_IN;
            req_latch.beats <= REQUESTED_BEAT_COUNT;
        end
    end

    // ****************************************
    // Local side strobes, grant and request
    // ****************************************
    always_comb begin
        next_taken_n = 1'b1;
        if (!LOCAL_READY_N && fifo_room && fetch_left > fetch_need) begin
            case (state)
                lmfbw_pkg::ST_ADDR: next_taken_n = 1'b0;
                lmfbw_pkg::ST_SETTLE: next_taken_n = DEVSEL_N;
                lmfbw_pkg::ST_DATA: next_taken_n = 1'b0;
                default: next_taken_n = 1'b1;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            taken_n <= 1'b1;
            fetch_left <= lmfbw_pkg::BEATS_ZERO;
        end else begin
            taken_n <= next_taken_n;
            if (state == lmfbw_pkg::ST_LOAD) begin
                fetch_left <= req_latch.beats;
            end else if (!taken_n && fetch_left != lmfbw_pkg::BEATS_ZERO) begin
                fetch_left <= fetch_left - 12'h001;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            grant_n <= 1'b1;
            req_n <= 1'b1;
        end else begin
            grant_n <= GNT_N;
            req_n <= LOCAL_WIDE_REQUEST_N;
        end
    end

    // Width decided once devsel appears; released when the bus goes idle
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wide_n <= 1'b1;
        end else if (state == lmfbw_pkg::ST_DECODE && !DEVSEL_N) begin
            wide_n <= ACK64_N;
        end else if (state == lmfbw_pkg::ST_IDLE) begin
            wide_n <= 1'b1;
        end
    end

    // ****************************************
    // Phase bookkeeping
    // ****************************************
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            done_q <= 1'b0;
            phases <= 32'h0000_0000;
        end else begin
            done_q <= phase_done;
            if (phase_done) begin
                phases <= phases + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // APB register slave, one wait state
    // ****************************************
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            control <= lmfbw_pkg::CONTROL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= PSEL && PENABLE && !pready;
            pslverr <= 1'b0;
            if (PSEL && PENABLE && !pready) begin
                prdata <= 32'h0000_0000;
                case (PADDR)
                    lmfbw_pkg::REG_CONTROL: begin
                        if (PWRITE) begin
                            control <= {31'h0000_0000, PWDATA[0]};
                        end else begin
                            prdata <= control;
                        end
                    end
                    lmfbw_pkg::REG_STATUS: begin
                        prdata <= {4'h0, fifo_level, remaining, 5'h00,
                                   3'(state), progress};
                    end
                    lmfbw_pkg::REG_PHASES: begin
                        prdata <= phases;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // lmfbw_top

// ### verif/lmfbw_top_assertions.sv
// Port checker for the fast back-to-back write bridge
`timescale 1ns/1ns
module lmfbw_top_checker (
    input wire logic MCLK, // clock
    input wire logic RESETN, // reset
    input wire logic GNT_N, // grant
    input wire logic REQ_N, // request
    input wire logic FRAME_N, // frame
    input wire logic FRAME_OE, // frame enable
    input wire logic IRDY_N, // irdy
    input wire logic IRDY_OE, // irdy enable
    input wire logic REQ64_N, // req64
    input wire logic TRDY_N, // trdy
    input wire logic LOCAL_WIDE_REQUEST_N, // local request
    input wire logic LOCAL_GRANT_N, // local grant
    input wire logic LOW_WORD_TAKEN_N, // low strobe
    input wire logic HIGH_WORD_TAKEN_N, // high strobe
    input wire logic DEVSEL_N, // target selected
    input wire logic ACK64_N, // wide accept
    input wire logic WIDE_TRANSFER_FLAG_N, // wide flag
    input wire logic [3:0] MASTER_PROGRESS_STATE // progress
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    property p_pair; LOW_WORD_TAKEN_N == HIGH_WORD_TAKEN_N; endproperty
    a_pair: assert property (p_pair) else $error("taken strobes differ");
    property p_lgnt; $past(RESETN) |-> LOCAL_GRANT_N == $past(GNT_N); endproperty
    a_lgnt: assert property (p_lgnt) else $error("local grant lag wrong");
    property p_req; $past(RESETN) |-> REQ_N == $past(LOCAL_WIDE_REQUEST_N); endproperty
    a_req: assert property (p_req) else $error("request not mirrored");
    property p_load; MASTER_PROGRESS_STATE == lmfbw_pkg::PROG_IDLE && !LOCAL_WIDE_REQUEST_N
        && !LOCAL_GRANT_N |=> MASTER_PROGRESS_STATE == lmfbw_pkg::PROG_ADDR_LOAD; endproperty
    a_load: assert property (p_load) else $error("no address loading");
    property p_addr; MASTER_PROGRESS_STATE == lmfbw_pkg::PROG_ADDR_LOAD && !GNT_N |=> !FRAME_N
        && !REQ64_N && FRAME_OE && MASTER_PROGRESS_STATE == lmfbw_pkg::PROG_BUS_TRANS; endproperty
    a_addr: assert property (p_addr) else $error("address phase missing");
    property p_irdy; IRDY_OE && !IRDY_N && TRDY_N |=> !IRDY_N; endproperty
    a_irdy: assert property (p_irdy) else $error("irdy dropped early");
    property p_last; FRAME_OE && FRAME_N |-> !IRDY_N && REQ64_N; endproperty
    a_last: assert property (p_last) else $error("bad final phase");
    property p_wait; MASTER_PROGRESS_STATE == lmfbw_pkg::PROG_CHAINED && $past(MASTER_PROGRESS_STATE)
        == lmfbw_pkg::PROG_BUS_TRANS |-> IRDY_N && LOW_WORD_TAKEN_N ##1 FRAME_N && !IRDY_N;
    endproperty
    a_wait: assert property (p_wait) else $error("bad chained wait");
    property p_frame; FRAME_OE && !FRAME_N |=> FRAME_OE; endproperty
    a_frame: assert property (p_frame) else $error("frame released early");
    property p_wide; $fell(DEVSEL_N) |=> WIDE_TRANSFER_FLAG_N == $past(ACK64_N); endproperty
    a_wide: assert property (p_wide) else $error("wide flag wrong");
endmodule // lmfbw_top_checker
bind lmfbw_top lmfbw_top_checker i_lmfbw_top_checker (.*);

// ### verif/lmfbw_target_model.sv
// Behavioural PCI target and arbiter facing the bridge
`timescale 1ns/1ns
module lmfbw_target_model (
    input wire logic MCLK, // clock
    input wire logic RESETN, // reset
    input wire logic REQ_N, // request
    input wire logic FRAME_N, // frame level
    input wire logic FRAME_OE, // frame enable
    input wire logic IRDY_N, // irdy level
    input wire logic IRDY_OE, // irdy enable
    input wire logic [63:0] AD_OUT, // address/data
    input wire logic [7:0] CBE_OUT, // command/enables
    input wire logic AD_OE, // address/data enable
    input wire logic CBE_OE, // command/enables enable
    input wire logic slow, // stall every other cycle
    output logic GNT_N, // grant
    output logic DEVSEL_N, // selected
    output logic TRDY_N, // ready
    output logic ACK64_N // wide accept
);
    logic stall;
    logic [71:0] got[$];
    logic [35:0] adr[$];
    // Undriven control lines are pulled up
    wire frame_l = !FRAME_OE || FRAME_N;
    wire irdy_l = !IRDY_OE || IRDY_N;
    wire done = !irdy_l && !TRDY_N;
    // Undriven address/data lines read back inverted so a missing enable shows
    wire [71:0] bus = (AD_OE && CBE_OE) ? {CBE_OUT, AD_OUT} : ~{CBE_OUT, AD_OUT};
    assign TRDY_N = DEVSEL_N || stall;
    assign ACK64_N = DEVSEL_N;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            GNT_N <= 1'b1;
            DEVSEL_N <= 1'b1;
            stall <= 1'b0;
        end else begin
            GNT_N <= REQ_N;
            // Release right after the final phase so a chained address is seen
            DEVSEL_N <= !((!frame_l || !irdy_l) && !(frame_l && done));
            stall <= slow && !stall;
            if (done) got.push_back(bus);
            if (!frame_l && DEVSEL_N && irdy_l) adr.push_back({bus[67:64], bus[31:0]});
        end
    end
endmodule // lmfbw_target_model

// ### verif/local_master_fast_b2b_write_tb.sv
// Testbench: local master, APB master and burst model for the bridge
`timescale 1ns/1ns
module local_master_fast_b2b_write_tb;
    logic MCLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
    logic LOCAL_READY_N = 1, LOCAL_WIDE_REQUEST_N = 1;
    logic [7:0] PADDR = 0, LOCAL_BYTE_ENABLES_IN = 8'hFF;
    logic [31:0] PWDATA = 0, PRDATA;
    logic [63:0] LOCAL_DATA_IN = 0, AD_OUT;
    logic [3:0] LOCAL_COMMAND_IN = 0, MASTER_PROGRESS_STATE;
    logic [11:0] REQUESTED_BEAT_COUNT = 0;
    logic PREADY, PSLVERR, GNT_N, REQ_N, FRAME_N, FRAME_OE, IRDY_N, IRDY_OE, REQ64_N, REQ64_OE;
    logic DEVSEL_N, TRDY_N, ACK64_N, AD_OE, CBE_OE, LOCAL_GRANT_N, WIDE_TRANSFER_FLAG_N;
    logic LOW_WORD_TAKEN_N, HIGH_WORD_TAKEN_N;
    logic [7:0] CBE_OUT;
    int bad_count = 0, total_checks = 0, seed = 55, phases = 0;
    logic [71:0] exp_w[$];
    logic [35:0] exp_a[$];
    lmfbw_top i_lmfbw_top (.*);
    lmfbw_target_model i_lmfbw_target_model (.*);
    initial forever #50 MCLK = ~MCLK;
    // ****************************************
    // Tasks
    // ****************************************
    task check(input logic [71:0] seen, input logic [71:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge MCLK);
        PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        r = {PSLVERR, PRDATA};
        PSEL <= 0; PENABLE <= 0;
    endtask
    // Called right after an edge; next address goes out as soon as the last word is taken
    task burst(input int len, input logic [31:0] a);
        logic [71:0] w;
        LOCAL_DATA_IN <= {32'h0, a}; LOCAL_COMMAND_IN <= 4'h7;
        REQUESTED_BEAT_COUNT <= 12'(len); LOCAL_WIDE_REQUEST_N <= 0;
        exp_a.push_back({4'h7, a});
        phases += len;
        do @(posedge MCLK); while (MASTER_PROGRESS_STATE !== lmfbw_pkg::PROG_ADDR_LOAD);
        LOCAL_WIDE_REQUEST_N <= 1;
        for (int i = 0; i < len; i++) begin
            w = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
            {LOCAL_BYTE_ENABLES_IN, LOCAL_DATA_IN} <= w;
            LOCAL_READY_N <= 0;
            exp_w.push_back(w);
            do @(posedge MCLK); while (LOW_WORD_TAKEN_N !== 1'b0);
        end
        LOCAL_READY_N <= 1;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        logic [32:0] r;
        int k;
        repeat (3) @(posedge MCLK);
        RESETN <= 1;
        apb(0, lmfbw_pkg::REG_CONTROL, 0, r);
        check(72'(r), 72'(lmfbw_pkg::CONTROL_RESET));
        apb(0, 8'h0C, 0, r);
        check(72'(r), 72'h1_0000_0000);
        apb(1, lmfbw_pkg::REG_CONTROL, 32'h1, r);
        burst(1, 32'h0000_1000);
        slow <= 1; // Stalled target lets words build up in the 8-word buffer
        repeat (3) burst(($unsigned($random(seed)) % 12) + 1, $random(seed) & 32'hFFFF_FFF8);
        k = 0;
        while (i_lmfbw_target_model.got.size() < exp_w.size() && k < 500) begin
            @(posedge MCLK); k++;
        end
        repeat (4) @(posedge MCLK);
        check(72'(i_lmfbw_target_model.got.size()), 72'(exp_w.size()));
        foreach (exp_w[i]) check(i_lmfbw_target_model.got[i], exp_w[i]);
        foreach (exp_a[i]) check(72'(i_lmfbw_target_model.adr[i]), 72'(exp_a[i]));
        apb(0, lmfbw_pkg::REG_PHASES, 0, r);
        check(72'(r), 72'(phases));
        apb(0, lmfbw_pkg::REG_STATUS, 0, r);
        check(72'(r[23:12]), 72'(lmfbw_pkg::BEATS_ZERO));
        check(72'(r[3:0]), 72'(lmfbw_pkg::PROG_IDLE));
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        bad_count++;
        tally_and_finish;
    end
endmodule // local_master_fast_b2b_write_tb
